// ### common/srfc_params.svh
// Purpose: Constants for the self refresh control block
// Assumes: 25 MHz core clock
// Notes: Counts are derived from times in ns
`ifndef SRFC_PARAMS_SVH
`define SRFC_PARAMS_SVH
`define SRFC_CLK_NS 40
`define SRFC_REFI_NS 7800
`define SRFC_RFC_NS 350
// Longest interval rounds down, least busy time rounds up
`define SRFC_REFI_CYC (`SRFC_REFI_NS / `SRFC_CLK_NS)
`define SRFC_RFC_CYC ((`SRFC_RFC_NS + `SRFC_CLK_NS - 1) / `SRFC_CLK_NS)
`define SRFC_ADDR_CFG 4'h0
`define SRFC_ADDR_STATUS 4'h4
`define SRFC_ADDR_REFCNT 4'h8
`define SRFC_CFG_RST 6'h02
`define SRFC_RATE_2X 3'h1
`define SRFC_RATE_4X 3'h2
`define SRFC_RATE_OTF2 3'h5
`define SRFC_RATE_OTF4 3'h6
`endif

// ### common/srfc_pkg.sv
// Purpose: Types for the self refresh control block
// Assumes: Pins arrive unsynchronised
// Notes: Whole module state is one packed struct
package srfc_pkg;
  typedef struct packed {
    logic ck;
    logic cke;
    logic chip_select_low;
    logic activate_low;
    logic row_strobe_low;
    logic col_strobe_low;
    logic write_enable_low;
    logic bank_group0;
    logic termination_control;
    logic reset_low;
  } srfc_pins_s;

  typedef enum logic [1:0] {
    SRFC_IDLE = 2'h1,
    SRFC_SELF = 2'h2
  } srfc_mode_e;

  typedef struct packed {
    logic [2:0] rate_mode;
    logic abort_en;
    logic dll_on;
    logic vref_keep;
  } srfc_cfg_s;

  typedef struct packed {
    srfc_pins_s sync1;
    srfc_pins_s sync2;
    logic ck_d;
    logic cke_at_edge;
    srfc_mode_e mode;
    srfc_cfg_s cfg;
    logic [1:0] rate_cnt;
    logic owed;
    logic ref_busy;
    logic [7:0] rfc_tmr;
    logic [7:0] refi_tmr;
    logic [15:0] refcnt;
    logic [15:0] rdata;
    logic term_en;
    logic dll_en;
    logic dll_rst;
    logic clk_run;
  } srfc_state_s;
endpackage

// ### logic/srfc_ctrl.sv
// Purpose: Device-side self refresh entry, residency, exit and abort
// Assumes: Pins and link clock are sampled by i_clk through two flops
// Notes: Link clock must be well below half of i_clk
//
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`include "srfc_params.svh"

module srfc_ctrl (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire srfc_pkg::srfc_pins_s i_pins,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  output logic o_in_self_refresh,
  output logic o_refresh_busy,
  output logic o_termination_en,
  output logic o_dll_enable,
  output logic o_dll_reset,
  output logic o_clk_run,
  output logic o_vref_gen_on,
  output logic o_catchup_owed
);
  srfc_pkg::srfc_state_s st;
  srfc_pkg::srfc_state_s next_st;
  srfc_pkg::srfc_pins_s p;
  logic rise;
  logic cmd_base;
  logic is_sre;
  logic is_ref;
  logic is_srx;
  logic mode_2x;
  logic mode_4x;
  logic ref_2x;
  logic ref_4x;
  logic cfg_wr;
  logic ref_start;
  logic [1:0] cnt_inc;

  assign p = st.sync2;
  assign rise = p.ck & ~st.ck_d;
  assign cmd_base = ~p.chip_select_low & p.activate_low & ~p.row_strobe_low & ~p.col_strobe_low;
  assign is_sre = rise & st.cke_at_edge & ~p.cke & cmd_base & p.write_enable_low;
  assign is_ref = rise & st.cke_at_edge & p.cke & cmd_base & p.write_enable_low;
  // exit is clock enable high with deselect
  assign is_srx = rise & p.cke & p.chip_select_low;
  assign mode_2x = (st.cfg.rate_mode == `SRFC_RATE_2X) | (st.cfg.rate_mode == `SRFC_RATE_OTF2);
  assign mode_4x = (st.cfg.rate_mode == `SRFC_RATE_4X) | (st.cfg.rate_mode == `SRFC_RATE_OTF4);
  assign ref_2x = (st.cfg.rate_mode == `SRFC_RATE_2X) | ((st.cfg.rate_mode == `SRFC_RATE_OTF2) & p.bank_group0);
  assign ref_4x = (st.cfg.rate_mode == `SRFC_RATE_4X) | ((st.cfg.rate_mode == `SRFC_RATE_OTF4) & p.bank_group0);
  assign cfg_wr = i_wr & (i_addr == `SRFC_ADDR_CFG);
  assign cnt_inc = st.rate_cnt + 2'h1;

  always_comb begin
    next_st = st;
    ref_start = 1'b0;
    next_st.sync1 = i_pins;
    next_st.sync2 = st.sync1;
    next_st.ck_d = st.sync2.ck;
    next_st.dll_rst = 1'b0;
    if (rise) begin
      next_st.cke_at_edge = p.cke;
    end
    if (st.ref_busy) begin
      if (st.rfc_tmr == 8'h01) begin
        next_st.ref_busy = 1'b0;
        next_st.refcnt = st.refcnt + 16'h0001;
      end else begin
        next_st.rfc_tmr = st.rfc_tmr - 8'h01;
      end
    end
    unique case (st.mode)
      srfc_pkg::SRFC_IDLE: begin
        next_st.term_en = p.termination_control;
        if (is_sre) begin
          next_st.mode = srfc_pkg::SRFC_SELF;
          next_st.owed = (mode_2x & st.rate_cnt[0]) | (mode_4x & (st.rate_cnt != 2'h0));
          ref_start = 1'b1;
          next_st.refi_tmr = 8'(`SRFC_REFI_CYC);
          next_st.term_en = 1'b0;
          next_st.dll_en = 1'b0;
          next_st.clk_run = 1'b0;
        end else if (is_ref) begin
          ref_start = 1'b1;
          if (ref_2x | ref_4x) begin
            next_st.rate_cnt = cnt_inc;
            if ((ref_2x & ~cnt_inc[0]) | (ref_4x & (cnt_inc == 2'h0))) begin
              next_st.owed = 1'b0;
            end
          end else begin
            next_st.rate_cnt = 2'h0;
            next_st.owed = 1'b0;
          end
        end
      end
      srfc_pkg::SRFC_SELF: begin
        if (st.refi_tmr == 8'h01) begin
          ref_start = 1'b1;
          next_st.refi_tmr = 8'(`SRFC_REFI_CYC);
        end else begin
          next_st.refi_tmr = st.refi_tmr - 8'h01;
        end
        if (is_srx) begin
          next_st.mode = srfc_pkg::SRFC_IDLE;
          next_st.rate_cnt = 2'h0;
          next_st.term_en = p.termination_control;
          next_st.dll_en = st.cfg.dll_on;
          next_st.dll_rst = st.cfg.dll_on;
          next_st.clk_run = 1'b1;
        end
      end
      default: begin
        next_st.mode = srfc_pkg::SRFC_IDLE;
      end
    endcase
    if (ref_start & ~next_st.ref_busy) begin
      next_st.ref_busy = 1'b1;
      next_st.rfc_tmr = 8'(`SRFC_RFC_CYC);
    end
    if ((st.mode == srfc_pkg::SRFC_SELF) & is_srx & st.cfg.abort_en) begin
      next_st.ref_busy = 1'b0;
      next_st.refcnt = st.refcnt;
    end
    // Device reset pin wins over everything above except the DLL reset pulse at exit and the refresh count increment
    if (~p.reset_low) begin
      next_st.mode = srfc_pkg::SRFC_IDLE;
      next_st.ref_busy = 1'b0;
      next_st.rate_cnt = 2'h0;
      next_st.owed = 1'b0;
      next_st.term_en = 1'b0;
      next_st.dll_en = st.cfg.dll_on;
      next_st.clk_run = 1'b1;
    end
    if (cfg_wr) begin
      next_st.cfg = i_wdata[5:0];
      next_st.rate_cnt = 2'h0;
    end
    next_st.rdata = 16'h0000;
    if (i_rd) begin
      unique case (i_addr)
        `SRFC_ADDR_CFG: next_st.rdata = {10'h000, st.cfg};
        `SRFC_ADDR_STATUS: next_st.rdata = {9'h000, st.term_en, st.dll_en, st.rate_cnt, st.owed,
                                            st.ref_busy, st.mode == srfc_pkg::SRFC_SELF};
        `SRFC_ADDR_REFCNT: next_st.rdata = st.refcnt;
        default: next_st.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st <= '0;
      st.mode <= srfc_pkg::SRFC_IDLE;
      st.cfg <= `SRFC_CFG_RST;
      st.dll_en <= 1'b1;
      st.clk_run <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign o_rdata = st.rdata;
  assign o_in_self_refresh = st.mode == srfc_pkg::SRFC_SELF;
  assign o_refresh_busy = st.ref_busy;
  assign o_termination_en = st.term_en;
  assign o_dll_enable = st.dll_en;
  assign o_dll_reset = st.dll_rst;
  assign o_clk_run = st.clk_run;
  // Generator stays up in residency only when software asks, trading power for write latency
  assign o_vref_gen_on = ~o_in_self_refresh | st.cfg.vref_keep;
  assign o_catchup_owed = st.owed;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  a_entry_taken: assert property (
    (st.mode == srfc_pkg::SRFC_IDLE) && is_sre && p.reset_low |=> o_in_self_refresh && !o_clk_run)
    else $error("self refresh entry not taken");
  a_entry_refresh: assert property (
    (st.mode == srfc_pkg::SRFC_IDLE) && is_sre && p.reset_low |=> o_refresh_busy)
    else $error("no refresh started at entry");
  a_timer_refresh: assert property (
    o_in_self_refresh && (st.refi_tmr == 8'h01) && !st.ref_busy && !is_srx && p.reset_low
    |=> o_refresh_busy && (st.refi_tmr == 8'(`SRFC_REFI_CYC)))
    else $error("internal timer did not refresh");
  a_term_off: assert property (
    o_in_self_refresh |-> !o_termination_en && !o_dll_enable)
    else $error("termination or DLL on in self refresh");
  a_dll_restart: assert property (
    o_in_self_refresh && is_srx && st.cfg.dll_on && p.reset_low |=> o_dll_reset && o_dll_enable ##1 !o_dll_reset)
    else $error("DLL not restarted at exit");
  a_inputs_ignored: assert property (
    o_in_self_refresh && !is_srx && p.reset_low && !cfg_wr |=> $stable(st.rate_cnt) && o_in_self_refresh)
    else $error("input acted on during self refresh");
  a_abort_drop: assert property (
    o_in_self_refresh && is_srx && st.cfg.abort_en && st.ref_busy && (st.rfc_tmr > 8'h01)
    |=> !o_refresh_busy && $stable(st.refcnt))
    else $error("abort did not drop refresh");
  a_owed_set: assert property (
    (st.mode == srfc_pkg::SRFC_IDLE) && is_sre && p.reset_low && mode_2x && st.rate_cnt[0]
    |=> o_catchup_owed)
    else $error("odd double rate count not flagged");
  a_rfc_length: assert property (
    o_refresh_busy && !$past(o_refresh_busy) && !is_srx |-> st.rfc_tmr == 8'(`SRFC_RFC_CYC))
    else $error("refresh busy time wrong");
endmodule

// ### verification/srfc_host_model.sv
// Purpose: Memory controller model driving the device pins
// Assumes: Link clock of 320 ns, eight core cycles per period
// Notes: Link clock stands still high between calls
`timescale 1ns/10ps
module srfc_host_model (
  input wire logic i_clk,
  output srfc_pkg::srfc_pins_s o_pins
);
  logic tog = 1'b0;
  initial o_pins = 10'h181;

  // Pins move at the falling half so they are stable around the rise
  task automatic ck_cycle(input srfc_pkg::srfc_pins_s p);
    repeat (4) @(posedge i_clk);
    o_pins <= p;
    repeat (4) @(posedge i_clk);
    o_pins.ck <= 1'b1;
  endtask

  task automatic desel(input logic cke, input logic term);
    tog = ~tog;
    ck_cycle({1'b0, cke, 1'b1, {5{tog}}, term, 1'b1});
  endtask

  // idle with clock enable high, then entry
  task automatic enter(input logic term);
    desel(1'b1, term);
    ck_cycle({7'b0001001, tog, term, 1'b1});
  endtask

  // clock enable held low; termination and reset held high, command and bank lines are junk meanwhile
  task automatic reside(input int n);
    repeat (n) begin
      tog = ~tog;
      ck_cycle({2'b00, tog, {4{~tog}}, tog, 2'b11});
    end
  endtask

  // trailing deselect lasts 8 core cycles, one short of the 9-cycle refresh cycle time
  task automatic refresh(input logic bg0);
    ck_cycle({7'b0101001, bg0, 2'b01});
    desel(1'b1, 1'b0);
  endtask

  // Device reset pin held low for a full link period, other pins left alone
  task automatic pin_reset();
    @(posedge i_clk);
    o_pins.reset_low <= 1'b0;
    repeat (8) @(posedge i_clk);
    o_pins.reset_low <= 1'b1;
  endtask

  // only deselects in the exit wait
  task automatic leave();
    desel(1'b1, 1'b0);
    desel(1'b1, 1'b0);
  endtask
endmodule

// ### verification/srfc_ctrl_bench.sv
// Purpose: Self-checking bench for the self refresh control block
// Assumes: Host model drives the pins, bench drives the register port
// Notes: Abort timing relies on the fixed spacing of internal refreshes
`timescale 1ns/10ps
`include "srfc_params.svh"
module srfc_ctrl_bench;
  logic clk, rst, wr, rd;
  logic [3:0] addr;
  logic [15:0] wdata, rdata, r0, r1;
  logic o_in_sr, o_busy, o_term, o_dll_en, o_dll_rst, o_clk_run, o_vref, o_owed;
  srfc_pkg::srfc_pins_s pins;
  int err_count = 0;
  int num_checks = 0;
  int t, m, s;
  logic [2:0] modes [5] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6};

  srfc_host_model HOST (.i_clk(clk), .o_pins(pins));
  srfc_ctrl DUT (.i_clk(clk), .i_rst(rst), .i_pins(pins), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .o_in_self_refresh(o_in_sr), .o_refresh_busy(o_busy),
    .o_termination_en(o_term), .o_dll_enable(o_dll_en), .o_dll_reset(o_dll_rst), .o_clk_run(o_clk_run),
    .o_vref_gen_on(o_vref), .o_catchup_owed(o_owed));

  always #20 clk = ~clk;

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk1(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // Waits on self refresh state (sel 0) or refresh busy (sel 1)
  task automatic wait_for(input logic sel, input logic v);
    int k;
    for (k = 0; k < 400; k++) begin
      @(posedge clk);
      #1;
      if ((sel ? o_busy : o_in_sr) === v) break;
    end
    if (k == 400) begin
      err_count++;
      $display("[FAIL] %0t wait ran out", $time);
      print_verdict();
    end
  endtask

  function automatic int next_tally(input int tl, input int md, input int single);
    return (single != 0 || md == 1) ? 0 : (tl + 1) % md;
  endfunction

  initial begin
    clk = 1'b0; rst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 4'h0; wdata = 16'h0000;
    void'($urandom(53));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    #1 chk1(o_dll_en, 1'b1);
    chk1(o_clk_run, 1'b1);
    rd_reg(`SRFC_ADDR_CFG, r0);
    chk16(r0, 16'h0002);
    wr_reg(`SRFC_ADDR_STATUS, 16'hFFFF);
    rd_reg(`SRFC_ADDR_STATUS, r0);
    chk16(r0, 16'h0020);
    wr_reg(4'hC, 16'($urandom()));
    rd_reg(4'hC, r0);
    chk16(r0, 16'h0000);
    wdata <= 16'($urandom());
    @(posedge clk);
    wr_reg(`SRFC_ADDR_CFG, wdata);
    rd_reg(`SRFC_ADDR_CFG, r0);
    chk16(r0, {10'h000, wdata[5:0]});
    foreach (modes[i]) begin
      m = (modes[i][1:0] == 2'h1) ? 2 : (modes[i][1:0] == 2'h2) ? 4 : 1;
      wr_reg(`SRFC_ADDR_CFG, {10'h000, modes[i], 3'b010});
      t = 0;
      repeat ($urandom_range(5, 0)) begin
        s = modes[i][2] ? $urandom_range(1, 0) : 0;
        HOST.refresh(s == 0);
        t = next_tally(t, m, s);
      end
      HOST.enter(1'b1);
      wait_for(1'b0, 1'b1);
      chk1(o_owed, t != 0);
      chk1(o_term, 1'b0);
      chk1(o_dll_en, 1'b0);
      chk1(o_clk_run, 1'b0);
      chk1(o_busy, 1'b1);
      chk1(o_vref, 1'b0);
      HOST.reside(10);
      repeat (100) @(posedge clk);
      HOST.reside(8);
      #1 chk1(o_in_sr, 1'b1);
      chk1(o_term, 1'b0);
      HOST.desel(1'b1, 1'b0);
      wait_for(1'b0, 1'b0);
      chk1(o_dll_rst, 1'b1);
      chk1(o_clk_run, 1'b1);
      chk1(o_dll_en, 1'b1);
      chk1(o_vref, 1'b1);
      @(posedge clk);
      #1 chk1(o_dll_rst, 1'b0);
      HOST.leave();
      // catch-up refreshes at the mode's rate
      repeat (m) HOST.refresh(1'b1);
      #1 chk1(o_owed, 1'b0);
      HOST.desel(1'b1, 1'b1);
      repeat (2) @(posedge clk);
      #1 chk1(o_term, 1'b1);
    end
    wr_reg(`SRFC_ADDR_CFG, 16'h0007);
    HOST.enter(1'b0);
    wait_for(1'b0, 1'b1);
    chk1(o_vref, 1'b1);
    HOST.reside(8);
    wait_for(1'b1, 1'b0);
    wait_for(1'b1, 1'b1);
    // Exit lands mid-way through the next internal refresh
    repeat (20) @(posedge clk);
    rd_reg(`SRFC_ADDR_REFCNT, r0);
    repeat (101) @(posedge clk);
    HOST.reside(8);
    HOST.desel(1'b1, 1'b0);
    wait_for(1'b0, 1'b0);
    chk1(o_busy, 1'b0);
    HOST.leave();
    rd_reg(`SRFC_ADDR_REFCNT, r1);
    chk16(r1, r0);
    // Extra refresh before re-entry, then the device reset pin in residency
    HOST.refresh(1'b1);
    HOST.enter(1'b0);
    wait_for(1'b0, 1'b1);
    HOST.reside(8);
    HOST.pin_reset();
    wait_for(1'b0, 1'b0);
    chk1(o_busy, 1'b0);
    chk1(o_dll_en, 1'b1);
    // Mid-run reset brings the configuration back to its reset value
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1 chk1(o_clk_run, 1'b1);
    rd_reg(`SRFC_ADDR_CFG, r0);
    chk16(r0, 16'h0002);
    print_verdict();
  end
endmodule
